// [rtl/wdt_pkg.sv]
// Package of constants and types for the watchdog/interval timer
package wdt_pkg;
    // Mode register field positions
    localparam int unsigned WDT_RUN_BIT = 7;
    localparam int unsigned WDT_MODE_BIT = 4;
    localparam int unsigned WDT_ACT_BIT = 3;
    // Clock select field in the second timer clock select register
    localparam int unsigned WDT_CLK_LSB = 0;
    localparam int unsigned WDT_CLK_W = 3;
    localparam int unsigned WDT_TIMER_CLOCK_SELECT_TWO_MASK_W = 8;
    // Reset values
    localparam logic [7:0] WDT_MODE_RST = 8'h00;
    localparam logic [7:0] WDT_TIMER_CLOCK_SELECT_TWO_RST = 8'h00;
    // Bits of the mode register that read back; others read zero
    localparam logic [7:0] WDT_MODE_RMASK = 8'h98;
    // Detection period exponents: codes 0..6 give 11..17, code 7 gives 19
    localparam int unsigned WDT_EXP_BASE = 11;
    localparam int unsigned WDT_EXP_TOP = 19;
    localparam logic [2:0] WDT_CODE_TOP = 3'h7;
    // Counter wide enough for 2^19 main clocks plus the oscillator divide
    localparam int unsigned WDT_CNT_W = 21;
    // Timing at the 10 MHz core clock
    localparam int unsigned WDT_CLK_NS = 100;
    localparam int unsigned WDT_RST_PULSE_NS = 100;
    localparam int unsigned WDT_RST_PULSE_CYC =
        (WDT_RST_PULSE_NS + WDT_CLK_NS - 1) / WDT_CLK_NS;

    // Register write strobe bundle
    typedef struct packed {
        logic       byte_we;
        logic       bit_we;
        logic [2:0] bit_idx;
        logic       bit_val;
        logic [7:0] wdata;
    } wdt_wr_type;

    // Event outputs
    typedef struct packed {
        logic sys_reset;
        logic nmi;
        logic irq;
    } wdt_evt_type;
endpackage

// [rtl/wdt_top.sv]
// Watchdog timer with interval timer mode
`timescale 1ns/1ps
// Operation
// - Reset clears mode register to zero
// - Mode register takes bit or byte writes
// - Action and mode bits are set-only
// - Run bit cannot be cleared by software
// - Mode bit 4 selects program-loop watchdog
// - Clock select bits 0-2 choose period
// - Writing run 1 clears and restarts counter
// - Overflow gives reset or NMI by bit 3
// - Counts in halt, stops in stop
// - After clear, overflow up to 0.5% early
// - Counting halts when subsystem clock selected
// - Codes map to 2^11..2^17 and 2^19
// - Main clock is oscillator or half of it
// - Bit 3 set, bit 4 clear: interval timer
// - Interval interrupt gated by mask; priority passed out
// - Interval interrupt has highest default priority
// - First interval after write may be short
// - Interval uses same clock field encoding
// - Reset clears clock select register
module wdt_top
    import wdt_pkg::*;
(
    // Clock and reset
    input  wire logic       CORE_CLK,
    input  wire logic       RST,
    // Register access
    input  wire logic       MODE_BYTE_WE,
    input  wire logic       MODE_BIT_WE,
    input  wire logic [2:0] MODE_BIT_IDX,
    input  wire logic       MODE_BIT_VAL,
    input  wire logic [7:0] MODE_WDATA,
    input  wire logic       TIMER_CLOCK_SELECT_TWO_WE,
    input  wire logic [7:0] TIMER_CLOCK_SELECT_TWO_WDATA,
    output logic      [7:0] MODE_RDATA,
    output logic      [7:0] TIMER_CLOCK_SELECT_TWO_RDATA,
    // System state
    input  wire logic       OSC_DIVIDE_SELECT,
    input  wire logic       STOP_MODE,
    input  wire logic       SUBCLK_SELECTED,
    input  wire logic       INTERVAL_IRQ_MASK,
    input  wire logic       INTERVAL_IRQ_PRIORITY,
    // Events
    output logic            SYS_RESET_REQ,
    output logic            NMI_REQ,
    output logic            INTERVAL_INTERRUPT,
    output logic            INTERVAL_IRQ_PRIO_OUT,
    output logic            RUNNING
);

    ////////////////////////////////////////////////////////////////////
    // Write decode
    wdt_wr_type wr;
    logic [7:0] mode_q;
    logic [7:0] mode_new;
    logic [7:0] timer_clock_select_two_q;
    logic       run_write;

    assign wr = '{byte_we: MODE_BYTE_WE, bit_we: MODE_BIT_WE,
                  bit_idx: MODE_BIT_IDX, bit_val: MODE_BIT_VAL,
                  wdata: MODE_WDATA};

    // Written value as software asks for it, before the set-only mask
    always_comb begin
        mode_new = mode_q;
        if (wr.byte_we) begin
            mode_new = wr.wdata;
        end else if (wr.bit_we) begin
            mode_new[wr.bit_idx] = wr.bit_val;
        end
    end

    // Only a write that targets the run bit with 1 restarts the count;
    // a bit write to another bit must not restart a running watchdog
    assign run_write = wr.byte_we ? wr.wdata[WDT_RUN_BIT] :
                       (wr.bit_we && wr.bit_val &&
                        wr.bit_idx == 3'(WDT_RUN_BIT));

    ////////////////////////////////////////////////////////////////////
    // Mode register: run, mode and action bits only ever set
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            mode_q <= WDT_MODE_RST;
        end else if (wr.byte_we || wr.bit_we) begin
            // Interval mode cannot be entered once watchdog is chosen
            mode_q <= mode_q | (mode_new & WDT_MODE_RMASK);
        end
    end

    // Clock select register, low field steers the period
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            timer_clock_select_two_q <= WDT_TIMER_CLOCK_SELECT_TWO_RST;
        end else if (TIMER_CLOCK_SELECT_TWO_WE) begin
            // Bit 3 reads as zero; caller should stop timer first
            timer_clock_select_two_q <= TIMER_CLOCK_SELECT_TWO_WDATA & 8'hf7;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Free-running prescaler; never cleared by a restart, which is what
    // makes the first period up to one count clock short
    logic [WDT_CNT_W-1:0] pre_q;
    logic                 count_en;
    logic                 wd_mode;
    logic                 iv_mode;
    logic [2:0]           sel;
    logic [4:0]           exp_sum;
    logic [WDT_CNT_W-1:0] last_val;

    assign count_en = !STOP_MODE && !SUBCLK_SELECTED;
    assign wd_mode = mode_q[WDT_MODE_BIT];
    assign iv_mode = mode_q[WDT_ACT_BIT] &&
                     !mode_q[WDT_MODE_BIT];
    assign sel = timer_clock_select_two_q[WDT_CLK_LSB +: WDT_CLK_W];

    // Period exponent in oscillator cycles; halved clock adds one
    always_comb begin
        if (sel == WDT_CODE_TOP) begin
            exp_sum = 5'(WDT_EXP_TOP);
        end else begin
            exp_sum = 5'(WDT_EXP_BASE) + {2'h0, sel};
        end
        exp_sum = exp_sum + {4'h0, !OSC_DIVIDE_SELECT};
        last_val = WDT_CNT_W'((22'h1 << exp_sum) - 22'h1);
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            pre_q <= '0;
        end else if (count_en) begin
            pre_q <= pre_q + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Main counter: counts core cycles in units of 2^(exp-8) prescaler
    // ticks; restart clears only the upper stage, so period is short by
    // at most 1/256 (under 0.5 %)
    logic [7:0] up_q;
    logic       tick;
    logic       ovf;
    logic [WDT_CNT_W-1:0] sub_mask;

    assign sub_mask = WDT_CNT_W'(last_val >> 8);
    assign tick = count_en && ((pre_q & sub_mask) == sub_mask);
    assign ovf = tick && (up_q == 8'hff) && mode_q[WDT_RUN_BIT];

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            up_q <= 8'h00;
        end else if (run_write) begin
            up_q <= 8'h00;
        end else if (mode_q[WDT_RUN_BIT] && tick) begin
            up_q <= up_q + 8'h01;  // interval mode wraps and repeats
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Event outputs, one-cycle pulses from flip-flops
    wdt_evt_type evt_q;

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            evt_q <= '0;
        end else begin
            evt_q.sys_reset <= ovf && wd_mode &&
                               mode_q[WDT_ACT_BIT];
            evt_q.nmi <= ovf && wd_mode &&
                         !mode_q[WDT_ACT_BIT];
            evt_q.irq <= ovf && iv_mode &&
                         !INTERVAL_IRQ_MASK;
        end
    end

    // Registered outputs
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            MODE_RDATA <= 8'h00;
            TIMER_CLOCK_SELECT_TWO_RDATA <= 8'h00;
            INTERVAL_IRQ_PRIO_OUT <= 1'b0;
            RUNNING <= 1'b0;
        end else begin
            MODE_RDATA <= mode_q;
            TIMER_CLOCK_SELECT_TWO_RDATA <= timer_clock_select_two_q;
            INTERVAL_IRQ_PRIO_OUT <= INTERVAL_IRQ_PRIORITY;
            RUNNING <= mode_q[WDT_RUN_BIT] && count_en;
        end
    end

    assign SYS_RESET_REQ = evt_q.sys_reset;
    assign NMI_REQ = evt_q.nmi;
    assign INTERVAL_INTERRUPT = evt_q.irq;

    ////////////////////////////////////////////////////////////////////
    // Checks
    a_mode_reset: assert property (
        @(posedge CORE_CLK)
        $fell(RST) |-> mode_q == WDT_MODE_RST)
        else $error("mode register not clear after reset");

    a_timer_clock_select_two_reset: assert property (
        @(posedge CORE_CLK)
        $fell(RST) |-> timer_clock_select_two_q == WDT_TIMER_CLOCK_SELECT_TWO_RST)
        else $error("clock select not clear after reset");

    a_timer_clock_select_two_bit3: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        TIMER_CLOCK_SELECT_TWO_WE |=> !timer_clock_select_two_q[3])
        else $error("clock select bit 3 not zero");

    a_sticky_act: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        mode_q[WDT_ACT_BIT] |=> mode_q[WDT_ACT_BIT])
        else $error("action bit cleared");

    a_sticky_mode: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        mode_q[WDT_MODE_BIT] |=> mode_q[WDT_MODE_BIT])
        else $error("mode bit cleared");

    a_run_held: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        mode_q[WDT_RUN_BIT] |=> mode_q[WDT_RUN_BIT])
        else $error("run bit cleared");

    a_byte_write: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        MODE_BYTE_WE |=>
        (mode_q & $past(MODE_WDATA) & WDT_MODE_RMASK) ==
        ($past(MODE_WDATA) & WDT_MODE_RMASK))
        else $error("byte write did not set bits");

    a_bit_write: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        MODE_BIT_WE && !MODE_BYTE_WE && MODE_BIT_VAL &&
        WDT_MODE_RMASK[MODE_BIT_IDX] |=> mode_q[$past(MODE_BIT_IDX)])
        else $error("bit write did not set bit");

    a_rdata_track: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        1'b1 |=> MODE_RDATA == $past(mode_q))
        else $error("mode read data stale");

    a_restart_clr: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        run_write |=> up_q == 8'h00)
        else $error("restart did not clear counter");

    a_no_restart: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        MODE_BIT_WE && !MODE_BYTE_WE && !tick &&
        MODE_BIT_IDX != 3'(WDT_RUN_BIT) |=> up_q == $past(up_q))
        else $error("write to other bit restarted counter");

    a_reset_kind: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        ovf && wd_mode && mode_q[WDT_ACT_BIT] |=>
        SYS_RESET_REQ && !NMI_REQ)
        else $error("overflow did not request reset");

    a_nmi_kind: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        ovf && wd_mode && !mode_q[WDT_ACT_BIT] |=>
        NMI_REQ && !SYS_RESET_REQ)
        else $error("overflow did not request nmi");

    a_stop_hold: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        STOP_MODE |=> $stable(pre_q))
        else $error("prescaler ran in stop");

    a_halt_count: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        count_en |=> pre_q == $past(pre_q) + 1'b1)
        else $error("prescaler did not advance");

    a_subclk_hold: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        SUBCLK_SELECTED |-> !ovf)
        else $error("overflow while on subsystem clock");

    a_subclk_freeze: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        SUBCLK_SELECTED && !run_write |=> $stable(up_q))
        else $error("counter moved on subsystem clock");

    a_irq_mode: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        INTERVAL_INTERRUPT |-> $past(iv_mode))
        else $error("interval interrupt outside interval mode");

    a_irq_masked: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        INTERVAL_IRQ_MASK |=> !INTERVAL_INTERRUPT)
        else $error("masked interval interrupt raised");

    a_prio_pass: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        1'b1 |=> INTERVAL_IRQ_PRIO_OUT == $past(INTERVAL_IRQ_PRIORITY))
        else $error("priority flag not passed");

    a_prescale_free: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        run_write && count_en |=> pre_q == $past(pre_q) + 1'b1)
        else $error("prescaler disturbed by restart");

    c_wd_reset: cover property (@(posedge CORE_CLK) SYS_RESET_REQ);
    c_wd_nmi: cover property (@(posedge CORE_CLK) NMI_REQ);
    c_interval: cover property (@(posedge CORE_CLK) INTERVAL_INTERRUPT);
    c_restart: cover property (@(posedge CORE_CLK) run_write && mode_q[7]);
    c_stop_run: cover property (@(posedge CORE_CLK) STOP_MODE && mode_q[7]);

endmodule // wdt_top

// [test/test_watchdog_interval_timer.sv]
// Self-checking testbench for the watchdog/interval timer
`timescale 1ns/1ps
module test_watchdog_interval_timer
    import wdt_pkg::*;
;
    typedef struct packed {
        wdt_evt_type kind;
        logic [31:0] lo;
        logic [31:0] hi;
    } wdt_note_type;

    logic        core_clk, rst, byte_we, bit_we, bit_val, tcl_we;
    logic [2:0]  bit_idx;
    logic [7:0]  wdata, tcl_wdata, mode_rdata, tcl_rdata;
    logic        osc, stop, subclk, mask, prio;
    logic        sys_rst, nmi, irq, prio_out, running;
    logic [31:0] cyc, t0;
    logic [7:0]  d;
    wdt_note_type q[$];
    int          n_errors = 0;
    int          tests_run = 0;
    localparam logic [31:0] P0 = 32'h800;

    wdt_top uut (
        .CORE_CLK(core_clk), .RST(rst), .MODE_BYTE_WE(byte_we),
        .MODE_BIT_WE(bit_we), .MODE_BIT_IDX(bit_idx),
        .MODE_BIT_VAL(bit_val), .MODE_WDATA(wdata), .TIMER_CLOCK_SELECT_TWO_WE(tcl_we),
        .TIMER_CLOCK_SELECT_TWO_WDATA(tcl_wdata), .MODE_RDATA(mode_rdata),
        .TIMER_CLOCK_SELECT_TWO_RDATA(tcl_rdata), .OSC_DIVIDE_SELECT(osc),
        .STOP_MODE(stop), .SUBCLK_SELECTED(subclk),
        .INTERVAL_IRQ_MASK(mask), .INTERVAL_IRQ_PRIORITY(prio),
        .SYS_RESET_REQ(sys_rst), .NMI_REQ(nmi), .INTERVAL_INTERRUPT(irq),
        .INTERVAL_IRQ_PRIO_OUT(prio_out), .RUNNING(running));

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    always @(posedge core_clk or posedge rst) begin
        if (rst) cyc <= 32'h0;
        else cyc <= cyc + 32'h1;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        if (n_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Window allows the short first period of the free prescaler
    task automatic expect_evt(input wdt_evt_type k, input logic [31:0] at,
                              input logic [31:0] p);
        wdt_note_type n;
        n.kind = k;
        n.lo = at - p / 256 - 3;
        n.hi = at + 3;
        q.push_back(n);
    endtask

    task automatic wait_empty(input int lim);
        for (int i = 0; i < lim && q.size() != 0; i++) @(posedge core_clk);
        if (q.size() != 0) begin
            n_errors++;
            $display("ERROR %0t expected event never came", $time);
            end_sim();
        end
    endtask

    task automatic do_reset;
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        q.delete();
    endtask

    task automatic wr_byte(input logic [7:0] v);
        @(posedge core_clk);
        byte_we <= 1'b1;
        wdata <= v;
        @(posedge core_clk);
        byte_we <= 1'b0;
    endtask

    task automatic wr_bit(input logic [2:0] idx);
        @(posedge core_clk);
        bit_we <= 1'b1;
        bit_idx <= idx;
        bit_val <= 1'b1;
        @(posedge core_clk);
        bit_we <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] em, input logic [7:0] et);
        repeat (2) @(posedge core_clk);
        #1;
        check(mode_rdata, em);
        check(tcl_rdata, et);
    endtask

    // Every event pulse must match the oldest note, kind and cycle window
    always @(posedge core_clk) begin
        if (!rst && (sys_rst | nmi | irq) === 1'b1) begin
            tests_run++;
            if (q.size() == 0 || {sys_rst, nmi, irq} !== q[0].kind ||
                cyc < q[0].lo || cyc > q[0].hi) begin
                n_errors++;
                $display("ERROR %0t unexpected event %b", $time,
                         {sys_rst, nmi, irq});
            end
            if (q.size() != 0) void'(q.pop_front());
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst <= 1'b1; byte_we <= 1'b0; bit_we <= 1'b0; bit_val <= 1'b0;
        tcl_we <= 1'b0; bit_idx <= 3'h0; wdata <= 8'h00; tcl_wdata <= 8'h00;
        osc <= 1'b1; stop <= 1'b0; subclk <= 1'b0; mask <= 1'b1;
        prio <= 1'b0;
        void'($urandom(32'h8158fd3a));
        do_reset();
        rd(8'h00, 8'h00);
        check({7'h0, running}, 8'h00);
        // Interval mode, masked first, then unmasked
        prio <= 1'($urandom);
        wr_byte(8'h88);
        t0 = cyc;
        wr_byte(8'h08);
        rd(8'h88, 8'h00);
        check({7'h0, prio_out}, {7'h0, prio});
        repeat (2 * P0 + 1000) @(posedge core_clk);
        mask <= 1'b0;
        expect_evt(3'b001, t0 + 3 * P0, P0);
        expect_evt(3'b001, t0 + 4 * P0, P0);
        wait_empty(3 * P0);
        // Watchdog with restart and frozen counting
        do_reset();
        wr_bit(3'h4);
        wr_bit(3'h7);
        rd(8'h90, 8'h00);
        check({7'h0, running}, 8'h01);
        repeat (1500) @(posedge core_clk);
        wr_bit(3'h7);
        expect_evt(3'b010, cyc + P0 + 1500, P0);
        stop <= 1'b1;
        repeat (1000) @(posedge core_clk);
        #1;
        check({7'h0, running}, 8'h00);
        stop <= 1'b0;
        subclk <= 1'b1;
        repeat (500) @(posedge core_clk);
        subclk <= 1'b0;
        wait_empty(P0 + 200);
        // Reset action, halved main clock, second clock code
        do_reset();
        osc <= 1'b0;
        d = 8'($urandom);
        @(posedge core_clk);
        tcl_we <= 1'b1;
        tcl_wdata <= {d[7:3], 3'h1};
        @(posedge core_clk);
        tcl_we <= 1'b0;
        wr_byte(8'h98);
        t0 = cyc;
        rd(8'h98, {d[7:4], 4'h1});
        expect_evt(3'b100, t0 + 4 * P0, 4 * P0);
        wait_empty(5 * P0);
        do_reset();
        end_sim();
    end
endmodule // test_watchdog_interval_timer
